// ==== logic/dbm_port.sv ====
// Data port of a 16-bank double-data-rate burst memory
// Function
// - Command, address and control are sampled only on rising command clock edges.
// - Write data is captured on both edges of the write data strobe.
// - Each data ball carries two bits per clock, one per half, both ways.
// - Read data is driven aligned to the read data strobes.
// - Bursts are 2, 4 or 8 words long as set in the mode setting.
// - The array has 16 banks selected by the bank address of each access.
// - Refresh is per bank with the row taken from an internal counter.
// - The wide part gives four read strobes, each with 9 data bits.
// - With two strobes, pair 0 times bits 8:0 and 26:18, pair 1 the rest.
// - Reads, writes and refreshes only work with the delay-locked loop enabled.
module dbm_port
  import dbm_pkg::*;
#(
  parameter int DQ_W  = DBM_DQ_W,
  parameter int COL_W = DBM_COL_W,
  parameter int ROW_W = DBM_ROW_W
) (
  input  wire logic                  sys_clk,         // System clock
  input  wire logic                  rst,             // Synchronous reset
  input  wire logic                  command_clock,   // Link command clock
  input  wire logic [2:0]            cmd,             // Command code
  input  wire logic [DBM_BANK_W-1:0] bank_addr,       // Bank address
  input  wire logic [COL_W-1:0]      addr,            // Column / mode bits
  input  wire logic                  write_data_strobe, // Write strobe
  input  wire logic [DQ_W-1:0]       dq_in,           // Data pins in
  input  wire logic [1:0]            write_byte_mask, // Mask per half
  output logic      [DQ_W-1:0]       dq_out,          // Data pins out
  output logic                       dq_oe,           // Data pin drive
  output logic      [DBM_QK_N-1:0]   read_data_strobe, // Read strobes
  output logic                       read_valid_flag, // Read data valid
  output logic      [ROW_W-1:0]      refresh_row,     // Last row refreshed
  output logic      [DBM_BANK_W-1:0] refresh_bank     // Last bank refreshed
);
  localparam int DEPTH = 1 << (DBM_BANK_W + COL_W);
  initial begin
    if (DQ_W != DBM_GROUP_W * DBM_QK_N)
      $error("dbm_port: DQ_W must be four groups of nine bits");
  end
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] ck_s_r;
  logic [2:0] dk_s_r;
  logic [2:0] cmd_s1_r, cmd_s2_r;
  logic [DBM_BANK_W-1:0] ba_s1_r, ba_s2_r;
  logic [COL_W-1:0] ad_s1_r, ad_s2_r;
  logic [DQ_W-1:0]  dq_s1_r, dq_s2_r;
  logic [1:0]       dm_s1_r, dm_s2_r;
  // Two flops before any use; third stage for edge finding
  always_ff @(posedge sys_clk) begin
    ck_s_r   <= {ck_s_r[1:0], command_clock};
    dk_s_r   <= {dk_s_r[1:0], write_data_strobe};
    cmd_s1_r <= cmd;
    cmd_s2_r <= cmd_s1_r;
    ba_s1_r  <= bank_addr;
    ba_s2_r  <= ba_s1_r;
    ad_s1_r  <= addr;
    ad_s2_r  <= ad_s1_r;
    dq_s1_r  <= dq_in;
    dq_s2_r  <= dq_s1_r;
    dm_s1_r  <= write_byte_mask;
    dm_s2_r  <= dm_s1_r;
  end
  // Edge detection from second and third stages
  wire ck_rise = ck_s_r[1] && !ck_s_r[2];
  wire ck_fall = !ck_s_r[1] && ck_s_r[2];
  wire dk_edge = dk_s_r[1] != dk_s_r[2];
  // ****************************************************************
  // Mode setting
  // ****************************************************************
  logic [1:0] bl_code_r;
  logic       dll_en_r;
  logic       qk2_r;
  wire  is_mrs = ck_rise && cmd_s2_r == DBM_CMD_MRS;
  // Mode bits written by the mode command
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bl_code_r <= DBM_BL_RST;
      dll_en_r  <= DBM_DLL_RST;
      qk2_r     <= DBM_QK2_RST;
    end else if (is_mrs) begin
      bl_code_r <= ad_s2_r[DBM_BL_LSB +: 2];
      dll_en_r  <= ad_s2_r[DBM_DLL_BIT];
      qk2_r     <= ad_s2_r[DBM_QK2_BIT];
    end
  end
  // Words per burst; an unused code falls back to two
  wire [3:0] bl_words = (bl_code_r == DBM_BL8) ? 4'h8 :
                        (bl_code_r == DBM_BL4) ? 4'h4 : 4'h2;
  // ****************************************************************
  // Burst control
  // ****************************************************************
  dbm_state_t       st_r, st_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [DBM_BANK_W+COL_W-1:0] wa_r, wa_nxt;
  logic [DQ_W-1:0]  mem [DEPTH];
  logic [ROW_W-1:0] row_ctr_r [DBM_BANKS];
  logic [ROW_W-1:0] refresh_row_r;
  logic [DBM_BANK_W-1:0] refresh_bank_r;
  wire  ok     = dll_en_r;
  wire  do_rd  = ck_rise && ok && cmd_s2_r == DBM_CMD_READ;
  wire  do_wr  = ck_rise && ok && cmd_s2_r == DBM_CMD_WRITE;
  wire  do_ref = ck_rise && ok && cmd_s2_r == DBM_CMD_REF;
  wire  idle   = st_r == DBM_IDLE;
  wire  fifo_in_ready;
  wire  fifo_out_valid;
  wire [DQ_W-1:0] fifo_out_data;
  // Read pushes one word per pass; the FIFO stalls the burst when full
  wire  rd_push = st_r == DBM_RD && fifo_in_ready;
  wire  wr_take = st_r == DBM_WR && dk_edge;
  // Next state
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    wa_nxt  = wa_r;
    case (st_r)
      DBM_IDLE: begin
        if (do_wr || do_rd) begin
          st_nxt  = do_wr ? DBM_WR : DBM_RD;
          cnt_nxt = bl_words;
          wa_nxt  = {ba_s2_r, ad_s2_r};
        end
      end
      DBM_WR: begin
        if (wr_take) begin
          cnt_nxt = cnt_r - 4'h1;
          wa_nxt  = wa_r + 1'b1;
          if (cnt_r == 4'h1) st_nxt = DBM_IDLE;
        end
      end
      DBM_RD: begin
        if (rd_push) begin
          cnt_nxt = cnt_r - 4'h1;
          wa_nxt  = wa_r + 1'b1;
          if (cnt_r == 4'h1) st_nxt = DBM_IDLE;
        end
      end
      default: st_nxt = DBM_IDLE;
    endcase
  end
  // State registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r  <= DBM_IDLE;
      cnt_r <= 4'h0;
      wa_r  <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      wa_r  <= wa_nxt;
    end
  end
  // Array write; mask bit chosen by the strobe half
  wire wr_mask = dk_s_r[1] ? dm_s2_r[0] : dm_s2_r[1];
  always_ff @(posedge sys_clk) begin
    if (wr_take && !wr_mask) mem[wa_r] <= dq_s2_r;
  end
  // Per-bank refresh with internal row counters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < DBM_BANKS; i++) row_ctr_r[i] <= '0;
      refresh_row_r  <= '0;
      refresh_bank_r <= '0;
    end else if (do_ref && idle) begin
      row_ctr_r[ba_s2_r] <= row_ctr_r[ba_s2_r] + 1'b1;
      refresh_row_r      <= row_ctr_r[ba_s2_r];
      refresh_bank_r     <= ba_s2_r;
    end
  end
  assign refresh_row  = refresh_row_r;
  assign refresh_bank = refresh_bank_r;
  // ****************************************************************
  // Read data path
  // ****************************************************************
  // One word leaves per clock half, i.e. on each command clock edge
  wire pop_now = fifo_out_valid && (ck_rise || ck_fall);
  dbm_fifo #(
    .WIDTH (DQ_W),
    .DEPTH (DBM_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (mem[wa_r]),
    .in_valid  (rd_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop_now)
  );
  logic [DQ_W-1:0] dq_r;
  logic            oe_r;
  logic            qk_r;
  // Data and strobe change on the same edge so they stay aligned
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_r <= '0;
      oe_r <= 1'b0;
      qk_r <= 1'b0;
    end else begin
      if (pop_now) dq_r <= fifo_out_data;
      if (ck_rise || ck_fall) oe_r <= fifo_out_valid;
      if (ck_rise || ck_fall) qk_r <= ck_rise;
    end
  end
  assign dq_out          = dq_r;
  assign dq_oe           = oe_r;
  assign read_valid_flag = oe_r;
  // Four strobes, one per nine bits; two-strobe mode parks 2 and 3
  assign read_data_strobe[0] = qk_r;
  assign read_data_strobe[1] = qk_r;
  assign read_data_strobe[2] = qk2_r ? 1'b0 : qk_r;
  assign read_data_strobe[3] = qk2_r ? 1'b0 : qk_r;
endmodule

// ==== logic/dbm_pkg.sv ====
// Package of constants for the burst memory data port
package dbm_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int DBM_BANKS      = 16;
  localparam int DBM_BANK_W     = 4;
  localparam int DBM_COL_W      = 6;
  localparam int DBM_ROW_W      = 8;
  localparam int DBM_DQ_W       = 36;
  localparam int DBM_GROUP_W    = 9;
  localparam int DBM_QK_N       = 4;
  // ****************************************************************
  // Command codes on the command pins
  // ****************************************************************
  localparam logic [2:0] DBM_CMD_NOP   = 3'h0;
  localparam logic [2:0] DBM_CMD_READ  = 3'h1;
  localparam logic [2:0] DBM_CMD_WRITE = 3'h2;
  localparam logic [2:0] DBM_CMD_REF   = 3'h3;
  localparam logic [2:0] DBM_CMD_MRS   = 3'h4;
  // ****************************************************************
  // Mode field codes, bit positions and reset values; read FIFO depth
  // ****************************************************************
  localparam logic [1:0] DBM_BL2       = 2'h0;
  localparam logic [1:0] DBM_BL4       = 2'h1;
  localparam logic [1:0] DBM_BL8       = 2'h2;
  localparam int         DBM_BL_LSB    = 0;
  localparam int         DBM_DLL_BIT   = 2;
  localparam int         DBM_QK2_BIT   = 3;
  localparam logic [1:0] DBM_BL_RST    = DBM_BL2;
  localparam logic       DBM_DLL_RST   = 1'b1;
  localparam logic       DBM_QK2_RST   = 1'b0;
  localparam int         DBM_FIFO_DEPTH = 4;
  // ****************************************************************
  // Port states
  // ****************************************************************
  typedef enum logic [1:0] {DBM_IDLE, DBM_WR, DBM_RD} dbm_state_t;
endpackage

// ==== logic/dbm_fifo.sv ====
// Small valid/ready FIFO placed in the read data path
module dbm_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,   // System clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Not full
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Pop request
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("dbm_fifo: DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  // Full and empty from pointer compare
  assign in_ready  = !((wp_r[AW] != rp_r[AW]) &&
                       (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem_r[rp_r[AW-1:0]];
  // Pointer update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop)  rp_r <= rp_r + 1'b1;
    end
  end
  // Storage
  always_ff @(posedge sys_clk) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data;
  end
endmodule

// ==== bench/dbm_port_sva.sv ====
// Checker of the burst memory data port outputs
module dbm_port_sva
  import dbm_pkg::*;
#(
  parameter int DQ_W  = DBM_DQ_W,
  parameter int COL_W = DBM_COL_W,
  parameter int ROW_W = DBM_ROW_W
) (
  input wire logic                  sys_clk,           // Clock
  input wire logic                  rst,               // Reset
  input wire logic                  command_clock,     // Link clock
  input wire logic [2:0]            cmd,               // Command
  input wire logic [DBM_BANK_W-1:0] bank_addr,         // Bank
  input wire logic [COL_W-1:0]      addr,              // Column
  input wire logic                  write_data_strobe, // Write strobe
  input wire logic [DQ_W-1:0]       dq_in,             // Data in
  input wire logic [1:0]            write_byte_mask,   // Mask
  input wire logic [DQ_W-1:0]       dq_out,            // Data out
  input wire logic                  dq_oe,             // Drive
  input wire logic [DBM_QK_N-1:0]   read_data_strobe,  // Strobes
  input wire logic                  read_valid_flag,   // Valid
  input wire logic [ROW_W-1:0]      refresh_row,       // Row
  input wire logic [DBM_BANK_W-1:0] refresh_bank       // Bank
);
  wire  [3:0] qs = read_data_strobe;
  logic [3:0] wc_r;
  logic       oe_r;
  logic       stb_r;
  // Counts the words of the read burst in flight
  always_ff @(posedge sys_clk) begin
    oe_r  <= dq_oe;
    stb_r <= qs[0];
    if (rst || !dq_oe) begin
      wc_r <= 4'h0;
    end else if (!oe_r || stb_r != qs[0]) begin
      wc_r <= wc_r + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence ck_still_s; $stable(command_clock) [*8]; endsequence
  sequence ref_s; $changed(refresh_bank) || $changed(refresh_row); endsequence
  oe_flag_a: assert property (dq_oe == read_valid_flag)
    else $error("valid flag differs from drive");
  strobe_pair_a: assert property (qs[1] == qs[0])
    else $error("strobe pair differs");
  upper_pair_a: assert property
    (qs[3:2] == 2'h0 || qs[3:2] == {2{qs[0]}}) else $error("upper strobes");
  strobe_follow_a: assert property
    (ck_still_s ##0 dq_oe |-> qs[0] == command_clock) else $error("strobe lag");
  data_hold_a: assert property
    (dq_oe && $past(dq_oe) && $stable(qs) |-> $stable(dq_out))
    else $error("data moved between strobe edges");
  burst_len_a: assert property
    ($fell(dq_oe) |-> wc_r inside {4'h2, 4'h4, 4'h8}) else $error("burst size");
  ref_bank_a: assert property
    ($changed(refresh_bank) |-> refresh_bank == $past(bank_addr, 4))
    else $error("refresh bank");
  ref_cmd_a: assert property (ref_s |-> $past(cmd, 4) == DBM_CMD_REF)
    else $error("refresh without command");
endmodule

// ==== bench/dbm_host.sv ====
// Host controller model: command clock, commands and write bursts
module dbm_host
  import dbm_pkg::*;
(
  output logic        command_clock,     // Link clock
  output logic [2:0]  cmd,               // Command
  output logic [3:0]  bank_addr,         // Bank
  output logic [5:0]  addr,              // Column or mode
  output logic        write_data_strobe, // Write strobe
  output logic [35:0] dq_in,             // Write data
  output logic [1:0]  write_byte_mask    // Write mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels, then a clock of 125 ns unrelated in phase
  initial begin
    {command_clock, write_data_strobe, write_byte_mask} = 4'h0;
    {cmd, bank_addr, addr, dq_in} = 49'h0;
    #3.3;
    forever #62.5 command_clock = ~command_clock;
  end
  // Command set on a falling edge, held across one rising edge
  task automatic issue(input logic [2:0] c, input logic [3:0] b,
                       input logic [5:0] a);
    @(negedge command_clock);
    cmd = c;
    bank_addr = b;
    addr = a;
    @(negedge command_clock);
    cmd = DBM_CMD_NOP;
    bank_addr = ~b; // Released lines show no stale value
    addr = ~a;
  endtask
  // Write burst of n words, one on each strobe edge
  task automatic write(input logic [3:0] b, input int n,
                       input logic [35:0] base);
    issue(DBM_CMD_WRITE, b, 6'h08);
    for (int i = 0; i < n; i++) begin
      dq_in = base + 36'(i);
      #31;
      write_data_strobe = ~write_data_strobe;
      #31;
    end
    dq_in = ~dq_in;
  endtask
endmodule

// ==== bench/tb.sv ====
// Bench top for the burst memory data port
module tb
  import dbm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        command_clock, write_data_strobe, dq_oe, read_valid_flag;
  logic [2:0]  cmd;
  logic [3:0]  bank_addr, read_data_strobe, refresh_bank;
  logic [5:0]  addr;
  logic [1:0]  write_byte_mask;
  logic [35:0] dq_in, dq_out;
  logic [7:0]  refresh_row;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // Clock of 5 ns and the parts under test
  always #2.5 sys_clk = ~sys_clk;
  dbm_host i_host (.*);
  dbm_port i_dut (.*);
  // Comparison, verdict and watchdog
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400_000;
    n_mismatch++;
    end_of_test;
  end
  // Reads one burst and compares each word as the strobes mark it
  task automatic rd(input logic [3:0] b, input int n, input logic [35:0] base,
                    input logic two);
    int   k = 0;
    logic oe_q = 1'b0;
    logic stb_q = 1'b0;
    fork i_host.issue(DBM_CMD_READ, b, 6'h08); join_none
    for (int t = 0; t < 600 && k < n; t++) begin
      @(posedge sys_clk);
      #1;
      if (read_valid_flag === 1'b1 && (!oe_q || stb_q !== read_data_strobe[0])) begin
        check(dq_out, base + 36'(k));
        check(36'(read_data_strobe[3:2]), two ? 36'h0 : 36'({2{stb_q ^ 1'b1}}));
        k++;
      end
      oe_q = read_valid_flag;
      stb_q = read_data_strobe[0];
    end
    check(36'(k), 36'(n));
    for (int t = 0; t < 100 && read_valid_flag !== 1'b0; t++) @(posedge sys_clk);
  endtask
  // Each burst length at the lowest and highest bank
  task automatic t_bursts;
    logic [35:0] ba;
    for (int c = 0; c < 3; c++) begin
      ba = 36'hA00000000 + 36'(c * 256);
      i_host.issue(DBM_CMD_MRS, 4'h0, 6'h04 | 6'(c));
      i_host.write(4'h0, 2 << c, ba);
      i_host.write(4'hF, 2 << c, ~ba);
      rd(4'h0, 2 << c, ba, 1'b0);
      rd(4'hF, 2 << c, ~ba, 1'b0);
    end
  endtask
  // Refresh reports its bank and steps the row counter
  task automatic t_refresh;
    logic [7:0] r;
    i_host.issue(DBM_CMD_REF, 4'h9, 6'h00);
    repeat (40) @(posedge sys_clk);
    check(36'(refresh_bank), 36'h9);
    r = refresh_row;
    i_host.issue(DBM_CMD_REF, 4'h9, 6'h00);
    repeat (40) @(posedge sys_clk);
    check(36'(refresh_row != r), 36'h1);
  endtask
  // Eight-word burst fills the four-word read buffer, stalls, drains in order
  task automatic t_fifo;
    i_host.issue(DBM_CMD_MRS, 4'h0, 6'h06);
    i_host.write(4'h3, 8, 36'h5A5A00000);
    rd(4'h3, 8, 36'h5A5A00000, 1'b0);
  endtask
  // Main sequence; the loop is switched off last, which blocks reads
  initial begin
    int hits = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(36'({dq_oe, read_data_strobe, refresh_row, refresh_bank}), 36'h0);
    t_fifo;
    t_bursts;
    i_host.issue(DBM_CMD_MRS, 4'h0, 6'h0D);
    i_host.write(4'h7, 4, 36'h312345670);
    rd(4'h7, 4, 36'h312345670, 1'b1);
    t_refresh;
    i_host.issue(DBM_CMD_MRS, 4'h0, 6'h00);
    fork i_host.issue(DBM_CMD_READ, 4'h0, 6'h08); join_none
    repeat (200) @(posedge sys_clk) hits += int'(read_valid_flag !== 1'b0);
    check(36'(hits), 36'h0);
    end_of_test;
  end
endmodule
bind dbm_port dbm_port_sva #(.DQ_W(DQ_W), .COL_W(COL_W), .ROW_W(ROW_W)) i_sva (.*);
